// [adcsci_top.sv]
/*
 * serial command and result interface of a 16-bit converter: start-bit
 * recognition, word decoding, per-input configuration storage, mode register,
 * result shifting and the conversion-done strobe.
 * assumes the serial pins arrive asynchronously and are sampled by i_clock,
 * which runs many times faster than the serial clock; the analog core sits
 * on i_clock and answers each request with one result word.
 */
`include "adcsci_params.svh"
`timescale 1ns/100ps
module adcsci_top (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_conversion_done_strobe,
    output logic o_conv_valid,
    output adcsci_pkg::adcsci_conv_req_t o_conv_req,
    input wire logic i_result_valid,
    output logic o_result_ready,
    input wire logic [15:0] i_result_data,
    output logic [7:0] o_mode_reg,
    output logic o_busy
);
    // pin synchronisers, two stages each, then an edge history stage
    logic cs_n_meta_reg;
    logic cs_n_sync_reg;
    logic sclk_meta_reg;
    logic sclk_sync_reg;
    logic sclk_prev_reg;
    logic din_meta_reg;
    logic din_sync_reg;

    // serial clock edges seen while selected
    logic sclk_rise;
    logic sclk_fall;

    // command receiver
    adcsci_pkg::adcsci_state_t state_reg;  // receiver state
    logic [6:0] cmd_shift_reg;  // bits after the start bit
    logic [2:0] cmd_count_reg;  // bits still to collect
    logic start_ok;  // a start bit may be taken now
    logic start_take;  // start bit captured this cycle

    // decoded fields of the collected word
    logic [2:0] word_chan;
    logic word_diff;
    logic [2:0] word_range;
    logic [2:0] word_tail_mode;
    logic cfg_write;
    logic conv_start;
    logic mode_write;
    logic mode_reset;

    // stored configuration, one entry per input
    adcsci_pkg::adcsci_cfg_t cfg_reg [`ADCSCI_NUM_CHAN];
    logic [7:0] mode_reg;  // mode-control register
    adcsci_pkg::adcsci_mode_t method;  // mode field of the register

    // conversion and result path
    logic busy_reg;  // request issued, result not yet in
    logic conv_valid_reg;
    adcsci_pkg::adcsci_conv_req_t conv_req_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic shift_load;  // move a result into the shifter
    logic have_data_reg;  // shifter holds unsent bits
    logic [15:0] out_shift_reg;  // result being sent
    logic [4:0] sent_count_reg;  // result bits already sent
    logic [4:0] early_thr;  // bits needed for an early start
    logic dout_reg;
    logic dout_oe_reg;
    logic strobe_reg;

    assign method = adcsci_pkg::adcsci_mode_t'(mode_reg[`ADCSCI_MODE_HI:`ADCSCI_MODE_LO]);

    // synchronise chip select, serial clock and data in
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cs_n_meta_reg <= 1'b1;
            cs_n_sync_reg <= 1'b1;
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else if (i_ce) begin
            cs_n_meta_reg <= i_cs_n;
            cs_n_sync_reg <= cs_n_meta_reg;
            sclk_meta_reg <= i_sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            din_meta_reg <= i_din;
            din_sync_reg <= din_meta_reg;
        end
    end

    // edges count only while selected; deselected activity is ignored
    assign sclk_rise = sclk_sync_reg && !sclk_prev_reg && !cs_n_sync_reg;
    assign sclk_fall = !sclk_sync_reg && sclk_prev_reg && !cs_n_sync_reg;

    // bits of the previous result that must be gone before an early start
    always_comb begin
        unique case (method)
            adcsci_pkg::ADCSCI_M_EXT_CLOCK: early_thr = `ADCSCI_THR_EXT_CLOCK;
            adcsci_pkg::ADCSCI_M_EXT_ACQ: early_thr = `ADCSCI_THR_EXT_ACQ;
            adcsci_pkg::ADCSCI_M_INT_CLOCK: early_thr = `ADCSCI_THR_INT_CLOCK;
            default: early_thr = `ADCSCI_RESULT_BITS;
        endcase
    end

    // idle and drained, or far enough into the previous result
    assign start_ok = (!busy_reg && !have_data_reg) ||
                      (have_data_reg && sent_count_reg >= early_thr);
    assign start_take = (state_reg == adcsci_pkg::ADCSCI_ST_IDLE) && sclk_rise &&
                        din_sync_reg && start_ok;

    // receiver: wait for start, collect seven bits, decode
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= adcsci_pkg::ADCSCI_ST_IDLE;
            cmd_shift_reg <= 7'h00;
            cmd_count_reg <= 3'h0;
        end else if (i_ce) begin
            unique case (state_reg)
                adcsci_pkg::ADCSCI_ST_IDLE: begin
                    // first high bit under chip select opens a word
                    if (start_take) begin
                        state_reg <= adcsci_pkg::ADCSCI_ST_COLLECT;
                        cmd_count_reg <= `ADCSCI_CMD_TAIL_BITS;
                    end
                end
                adcsci_pkg::ADCSCI_ST_COLLECT: begin
                    // a word cut short by chip select is dropped
                    if (cs_n_sync_reg) begin
                        state_reg <= adcsci_pkg::ADCSCI_ST_IDLE;
                    end else if (sclk_rise) begin
                        cmd_shift_reg <= {cmd_shift_reg[5:0], din_sync_reg};
                        cmd_count_reg <= cmd_count_reg - 3'h1;
                        if (cmd_count_reg == 3'h1) begin
                            state_reg <= adcsci_pkg::ADCSCI_ST_DECODE;
                        end
                    end
                end
                adcsci_pkg::ADCSCI_ST_DECODE: begin
                    // one cycle to act on the word
                    state_reg <= adcsci_pkg::ADCSCI_ST_IDLE;
                end
                default: begin
                    state_reg <= adcsci_pkg::ADCSCI_ST_IDLE;
                end
            endcase
        end
    end

    // field split of the word {start, cmd_shift_reg}
    assign word_chan = cmd_shift_reg[`ADCSCI_CHAN_HI:`ADCSCI_CHAN_LO];
    assign word_diff = cmd_shift_reg[`ADCSCI_DIFF_BIT];
    assign word_range = cmd_shift_reg[`ADCSCI_RANGE_HI:`ADCSCI_RANGE_LO];
    assign word_tail_mode = cmd_shift_reg[`ADCSCI_MODE_HI:`ADCSCI_MODE_LO];

    // word type: nonzero range configures, zero range starts or sets mode
    always_comb begin
        cfg_write = 1'b0;
        conv_start = 1'b0;
        mode_write = 1'b0;
        mode_reset = 1'b0;
        if (state_reg == adcsci_pkg::ADCSCI_ST_DECODE) begin
            if (word_range != `ADCSCI_RANGE_NONE) begin
                // reserved differential codes leave the entry alone
                if (!word_diff || word_range == 3'h1 || word_range == 3'h4 ||
                    word_range == 3'h7) begin
                    cfg_write = 1'b1;
                end
            end else if (!word_diff) begin
                conv_start = 1'b1;
            end else begin
                // mode word; reserved fields change nothing
                unique case (adcsci_pkg::adcsci_mode_t'(word_tail_mode))
                    adcsci_pkg::ADCSCI_M_RESET: mode_reset = 1'b1;
                    adcsci_pkg::ADCSCI_M_RSVD3, adcsci_pkg::ADCSCI_M_RSVD5: mode_write = 1'b0;
                    default: mode_write = 1'b1;
                endcase
            end
        end
    end

    // per-input configuration entries
    generate
        for (genvar ch = 0; ch < `ADCSCI_NUM_CHAN; ch++) begin : g_cfg
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    cfg_reg[ch] <= '{diff_single_select: 1'b0, range_code: `ADCSCI_RANGE_RESET};
                end else if (i_ce) begin
                    if (mode_reset) begin
                        // reset word restores single-ended full bipolar
                        cfg_reg[ch] <= '{diff_single_select: 1'b0, range_code: `ADCSCI_RANGE_RESET};
                    end else if (cfg_write && word_chan == 3'(ch)) begin
                        cfg_reg[ch] <= '{diff_single_select: word_diff, range_code: word_range};
                    end
                end
            end
        end
    endgenerate

    // mode-control register: method and power state
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= `ADCSCI_MODE_RESET;
        end else if (i_ce) begin
            if (mode_reset) begin
                mode_reg <= `ADCSCI_MODE_RESET;
            end else if (mode_write) begin
                mode_reg <= {1'b1, word_tail_mode, `ADCSCI_MODE_TAIL};
            end
        end
    end

    // conversion request: stored entry of the addressed (positive) input
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            conv_valid_reg <= 1'b0;
            conv_req_reg <= '0;
            busy_reg <= 1'b0;
        end else if (i_ce) begin
            conv_valid_reg <= conv_start;
            if (conv_start) begin
                conv_req_reg <= '{channel: word_chan, cfg: cfg_reg[word_chan], method: method};
            end
            // the result entering the FIFO ends the conversion
            if (conv_start) begin
                busy_reg <= 1'b1;
            end else if (i_result_valid && fifo_in_ready) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // results wait here until the shifter is free
    adcsci_fifo #(
        .WIDTH(16),
        .DEPTH(`ADCSCI_FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(i_result_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_result_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(shift_load),
        .o_out_data(fifo_out_data)
    );

    // the shifter takes a new word once the previous one is gone
    assign shift_load = fifo_out_valid && !have_data_reg;

    // result shifter: MSB first, one bit per falling edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            out_shift_reg <= 16'h0000;
            sent_count_reg <= 5'h00;
            have_data_reg <= 1'b0;
            dout_reg <= 1'b0;
        end else if (i_ce) begin
            if (shift_load) begin
                out_shift_reg <= fifo_out_data;
                sent_count_reg <= 5'h00;
                have_data_reg <= 1'b1;
            end else if (sclk_fall && have_data_reg) begin
                dout_reg <= out_shift_reg[15];
                out_shift_reg <= {out_shift_reg[14:0], 1'b0};
                sent_count_reg <= sent_count_reg + 5'h01;
                if (sent_count_reg == `ADCSCI_RESULT_BITS - 5'h01) begin
                    have_data_reg <= 1'b0;
                end
            end else if (sclk_fall) begin
                // nothing to send: the line reads low
                dout_reg <= 1'b0;
            end
        end
    end

    // output enable follows synchronised chip select
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dout_oe_reg <= 1'b0;
        end else if (i_ce) begin
            dout_oe_reg <= !cs_n_sync_reg;
        end
    end

    // done strobe: driven at all times, rises with a ready result except in the external clock method, where it is held low
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            strobe_reg <= 1'b0;
        end else if (i_ce) begin
            if (method == adcsci_pkg::ADCSCI_M_EXT_CLOCK) begin
                strobe_reg <= 1'b0;
            end else if (shift_load) begin
                // a ready result wins over a start bit in the same cycle
                strobe_reg <= 1'b1;
            end else if (start_take) begin
                strobe_reg <= 1'b0;
            end
        end
    end

    assign o_dout = dout_reg;
    assign o_dout_oe = dout_oe_reg;
    assign o_conversion_done_strobe = strobe_reg;
    assign o_conv_valid = conv_valid_reg;
    assign o_conv_req = conv_req_reg;
    assign o_result_ready = fifo_in_ready;
    assign o_mode_reg = mode_reg;
    assign o_busy = busy_reg;

endmodule : adcsci_top

// [adcsci_params.svh]
/*
 * constants of the serial command interface: word field positions,
 * reset values and start-bit thresholds.
 * assumes inclusion by bare name from every file that needs them.
 */
`ifndef ADCSCI_PARAMS_SVH
`define ADCSCI_PARAMS_SVH

// input word field positions
`define ADCSCI_CHAN_HI 6
`define ADCSCI_CHAN_LO 4
`define ADCSCI_DIFF_BIT 3
`define ADCSCI_RANGE_HI 2
`define ADCSCI_RANGE_LO 0
`define ADCSCI_MODE_HI 6
`define ADCSCI_MODE_LO 4

// word sizes and counts
`define ADCSCI_RESULT_BITS 5'h10
`define ADCSCI_CMD_TAIL_BITS 3'h7
`define ADCSCI_NUM_CHAN 8
`define ADCSCI_FIFO_DEPTH 32

// reset values: external clock method, single-ended bipolar full reference
`define ADCSCI_MODE_RESET 8'h88
`define ADCSCI_RANGE_RESET 3'h7
`define ADCSCI_RANGE_NONE 3'h0
`define ADCSCI_MODE_TAIL 4'h8

// result bits that must have left before an early start bit is taken
`define ADCSCI_THR_EXT_CLOCK 5'h0d
`define ADCSCI_THR_EXT_ACQ 5'h09
`define ADCSCI_THR_INT_CLOCK 5'h0c

`endif

// [adcsci_pkg.sv]
/*
 * types of the serial command interface.
 * assumes nothing beyond the constants header.
 */
package adcsci_pkg;

    // mode field values
    typedef enum logic [2:0] {
        ADCSCI_M_EXT_CLOCK = 3'h0,
        ADCSCI_M_EXT_ACQ = 3'h1,
        ADCSCI_M_INT_CLOCK = 3'h2,
        ADCSCI_M_RSVD3 = 3'h3,
        ADCSCI_M_RESET = 3'h4,
        ADCSCI_M_RSVD5 = 3'h5,
        ADCSCI_M_PART_DOWN = 3'h6,
        ADCSCI_M_FULL_DOWN = 3'h7
    } adcsci_mode_t;

    // command receiver states, gray along idle, collect, decode
    typedef enum logic [1:0] {
        ADCSCI_ST_IDLE = 2'h0,
        ADCSCI_ST_COLLECT = 2'h1,
        ADCSCI_ST_DECODE = 2'h3
    } adcsci_state_t;

    // stored per-input configuration
    typedef struct packed {
        logic diff_single_select;
        logic [2:0] range_code;
    } adcsci_cfg_t;

    // conversion request handed to the analog core
    typedef struct packed {
        logic [2:0] channel;
        adcsci_cfg_t cfg;
        adcsci_mode_t method;
    } adcsci_conv_req_t;

endpackage : adcsci_pkg

// [adcsci_fifo.sv]
/*
 * result FIFO between the analog core and the output shifter.
 * assumes one clock, synchronous use, and a clock enable that freezes it.
 */
`timescale 1ns/100ps
module adcsci_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];  // storage words
    logic [AW-1:0] wr_ptr_reg;  // write index
    logic [AW-1:0] rd_ptr_reg;  // read index
    logic [CW-1:0] count_reg;  // words held
    logic [CW-1:0] count_next;
    logic in_ready_reg;  // registered not-full
    logic push;
    logic pop;

    assign push = i_ce && i_in_valid && in_ready_reg;
    assign pop = i_ce && o_out_valid && i_out_ready;
    assign o_in_ready = in_ready_reg;
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];

    // occupancy after this cycle's push and pop
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + CW'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CW'(1);
        end
    end

    // storage write
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointers, count and ready
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b1;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            count_reg <= count_next;
            in_ready_reg <= (count_next < CW'(DEPTH));
        end
    end

endmodule : adcsci_fifo

// [adcsci_host.sv]
/* host model: serial bus master that drives the command interface.
   assumes the bench resolves the data-out wire and calls these tasks. */
`timescale 1ns/100ps
module adcsci_host (
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input wire logic i_dout
);
    // idle: deselected, clock parked low, data low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // move chip select, then let the sync flops catch up
    task automatic sel(input logic v);
        o_cs_n = v;
        #40;
    endtask : sel
    // n clocks of 80 ns: data set while low, result bit taken before each rise after the first and once after the last fall
    task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0;
        for (int i = 0; i < n; i++) begin
            o_din = tx[15-i];
            #40;
            if (i > 0) rx = {rx[14:0], i_dout};
            o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
        end
        #40 rx = {rx[14:0], i_dout};
        o_din = 1'b0;
    endtask : shift
endmodule : adcsci_host

// [adcsci_asserts.sv]
/* checker: pin-level timing of the serial command interface.
   assumes i_ce high while judged; bound to the top module below. */
`timescale 1ns/100ps
module adcsci_checker (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_result_valid,
    input wire logic o_dout,
    input wire logic o_dout_oe,
    input wire logic o_conversion_done_strobe,
    input wire logic o_conv_valid,
    input wire adcsci_pkg::adcsci_conv_req_t o_conv_req,
    input wire logic o_result_ready,
    input wire logic [7:0] o_mode_reg,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst || !i_ce);
    logic [2:0] mode_f; // mode field of the register
    assign mode_f = o_mode_reg[6:4];
    // chip select steady past the sync delay
    sequence s_cs_off; i_cs_n [*5]; endsequence
    sequence s_cs_on; !i_cs_n [*5]; endsequence
    // the core hands over a result
    sequence s_take; o_busy && i_result_valid && o_result_ready; endsequence
    a_out_release: assert property (s_cs_off |-> !o_dout_oe)
        else $error("data out driven while deselected");
    a_out_drive: assert property (s_cs_on |-> o_dout_oe)
        else $error("data out not driven while selected");
    a_dout_fall: assert property (o_dout_oe && $past(o_dout_oe) && $changed(o_dout) |-> !i_sclk)
        else $error("data out moved outside a falling edge");
    a_strobe_mode0: assert property ((mode_f == 3'h0) [*2] |-> !o_conversion_done_strobe)
        else $error("strobe high in external clock method");
    a_strobe_rise: assert property ($rose(o_conversion_done_strobe) |-> mode_f inside {3'h1, 3'h2} && !o_busy)
        else $error("strobe rose without a finished result");
    a_strobe_fall: assert property ($fell(o_conversion_done_strobe) |-> !$past(i_cs_n, 4))
        else $error("strobe fell without a selected start");
    a_req_method: assert property (o_conv_valid |-> o_conv_req.method == o_mode_reg[6:4] && o_busy)
        else $error("request method differs from mode");
    a_req_pulse: assert property (o_conv_valid |=> !o_conv_valid [*8])
        else $error("request pulse too long");
    a_busy_end: assert property (s_take |=> !o_busy)
        else $error("busy stayed after result taken");
    a_busy_hold: assert property (o_busy && !(i_result_valid && o_result_ready) |=> o_busy)
        else $error("busy dropped without a result");
    a_mode_legal: assert property (!(o_mode_reg[6:4] inside {3'h3, 3'h5}))
        else $error("reserved mode stored");
    a_mode_quiet: assert property ($changed(o_mode_reg) |-> !$past(i_cs_n, 4))
        else $error("mode changed while deselected");
endmodule : adcsci_checker

bind adcsci_top adcsci_checker chk (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_result_valid(i_result_valid), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_conversion_done_strobe(o_conversion_done_strobe), .o_conv_valid(o_conv_valid),
    .o_conv_req(o_conv_req), .o_result_ready(o_result_ready), .o_mode_reg(o_mode_reg), .o_busy(o_busy));

// [testbench.sv]
/* bench: host model on the serial pins, a core stub on the result side.
   assumes design, checker and host model are compiled before it. */
`timescale 1ns/100ps
module testbench;
    logic clk, rst, ce, rv, cs_n, sclk, din, dout, oe, strb, cv, rr, busy; // pins
    logic [15:0] rd, core_d, rx; // result words
    logic [7:0] mode, e; // mode register, its expectation
    adcsci_pkg::adcsci_conv_req_t req;
    int num_errors = 0, cmp_count = 0, cyc = 0, n;
    int lat = 15; // core stub answer delay: short for mode 0, longer than a byte for modes 1 and 2
    wire dout_w = oe ? dout : 1'bz; // shared data-out wire
    // row: config byte, start byte, expected stored config
    typedef struct packed { logic [7:0] cfg, st; logic [3:0] ecfg; } adcsci_row_t;
    adcsci_row_t rows [13] = '{20'h81801, 20'h92902, 20'ha3a03, 20'hb4b04, 20'hc5c05, 20'hd6d06,
        20'he7e07, 20'h89809, 20'haca0c, 20'hcfc0f, 20'h9b902, 20'hbdb04, 20'hded06};
    adcsci_top uut (.i_clock(clk), .i_rst(rst), .i_ce(ce), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
        .o_dout(dout), .o_dout_oe(oe), .o_conversion_done_strobe(strb), .o_conv_valid(cv), .o_conv_req(req),
        .i_result_valid(rv), .o_result_ready(rr), .i_result_data(rd), .o_mode_reg(mode), .o_busy(busy));
    adcsci_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout_w));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    // core stub: answers each request after lat cycles
    initial begin
        rv = 1'b0;
        rd = 16'h0;
        forever begin
            @(posedge clk);
            if (cv === 1'b1) begin
                repeat (lat) @(posedge clk);
                #1 rv = 1'b1;
                rd = core_d;
                do @(posedge clk); while (rr !== 1'b1);
                #1 rv = 1'b0;
            end
        end
    end
    task automatic chk_bit(input string nm, input logic x, input logic g);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s exp %b got %b", nm, x, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string nm, input logic [15:0] x, input logic [15:0] g);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, x, g);
        end
    endtask : chk_word
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // one selected frame of n bits
    task automatic frame(input logic [15:0] tx, input int nb);
        host.sel(1'b0);
        host.shift(tx, nb, rx);
        host.sel(1'b1);
    endtask : frame
    // bounded wait for the strobe
    task automatic wait_strb();
        n = 0;
        while (strb !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        #1 chk_bit("strobe", 1'b1, strb);
    endtask : wait_strb
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        core_d = 16'h0;
        e = 8'h88;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        // ordinary cases: configure, start, read back
        foreach (rows[i]) begin
            core_d = {rows[i].cfg, rows[i].st};
            frame({rows[i].cfg, 8'h0}, 8);
            host.sel(1'b0);
            host.shift({rows[i].st, 8'h0}, 8, rx);
            host.shift(16'h0, 16, rx);
            host.sel(1'b1);
            chk_word("req", {4'h0, rows[i].st[6:4], rows[i].ecfg, 3'h0}, {4'h0, req});
            chk_word("result", core_d, rx);
        end
        // a frozen clock enable, then clocking with chip select high: both ignored
        ce = 1'b0;
        frame(16'h9800, 8);
        ce = 1'b1;
        host.shift(16'h9800, 8, rx);
        chk_word("mode", 16'h0088, {8'h0, mode});
        chk_bit("oe", 1'b0, oe);
        // every mode field value, reserved ones dropped, reset restores
        for (int m = 0; m < 8; m++) begin
            frame({1'b1, 3'(m), 12'h800}, 8);
            e = (m == 4) ? 8'h88 : (m == 3 || m == 5) ? e : {1'b1, 3'(m), 4'h8};
            chk_word("mode", {8'h0, e}, {8'h0, mode});
        end
        // external acquisition, early start after nine bits
        lat = 300;
        frame(16'h9800, 8);
        core_d = 16'h9a5c;
        frame(16'h8000, 16);
        wait_strb();
        host.sel(1'b0);
        host.shift(16'h0, 9, rx);
        host.shift(16'hc000, 16, rx);
        chk_bit("strobe", 1'b0, strb);
        host.sel(1'b1);
        wait_strb();
        chk_word("req", {4'h0, 3'h4, 4'h7, 3'h1}, {4'h0, req});
        frame(16'h0, 16);
        chk_word("result", core_d, rx);
        // external clock, early start after thirteen bits
        lat = 15;
        frame(16'h8800, 8);
        core_d = 16'h5aa5;
        host.sel(1'b0);
        host.shift(16'hb000, 8, rx);
        host.shift(16'h0, 13, rx);
        host.shift(16'hf000, 8, rx);
        host.shift(16'h0, 16, rx);
        host.sel(1'b1);
        chk_word("req", {4'h0, 3'h7, 4'h7, 3'h0}, {4'h0, req});
        chk_word("result", core_d, rx);
        // buffer: fill until refused, drain with stalls
        #1 rv = 1'b1;
        rd = 16'h0100;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (rr === 1'b1) n++;
            #1 rd = 16'h0100 + 16'(n);
        end
        rv = 1'b0;
        chk_bit("full", 1'b0, rr);
        chk_bit("count", 1'b1, n == 32 || n == 33);
        host.sel(1'b0);
        for (int k = 0; k < n; k++) begin
            host.shift(16'h0, 16, rx);
            chk_word("drain", 16'h0100 + 16'(k), rx);
            #200;
        end
        host.sel(1'b1);
        chk_bit("empty", 1'b1, rr);
        // internal clock, early start after twelve bits
        lat = 300;
        frame(16'ha800, 8);
        frame(16'ha000, 8);
        wait_strb();
        host.sel(1'b0);
        host.shift(16'h0, 12, rx);
        host.shift(16'h9000, 8, rx);
        host.sel(1'b1);
        wait_strb();
        chk_word("req", {4'h0, 3'h1, 4'h7, 3'h2}, {4'h0, req});
        frame(16'h0, 16);
        chk_word("result", core_d, rx);
        // second reset in mid-run
        rst = 1'b1;
        repeat (2) @(posedge clk);
        chk_word("mode", 16'h0088, {8'h0, mode});
        chk_bit("strobe", 1'b0, strb);
        chk_bit("ready", 1'b1, rr);
        #1 rst = 1'b0;
        // first word after the release is taken
        frame(16'h9800, 8);
        chk_word("mode", 16'h0098, {8'h0, mode});
        complete_run();
    end
endmodule : testbench
